// File: dcap_regs.sv
// device capability words and capability-masked clock gating words
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "dcap_params.svh"

module dcap_regs (
   input  wire  logic               core_clk,
   input  wire  logic               rst,
   input  wire  dcap_pkg::dcap_req_t req,
   output logic [31:0]              reg_rdata,
   output logic                     reg_rvalid,
   output logic [31:0]              run_gating_word_zero,
   output logic [31:0]              sleep_gating_word_zero,
   output logic [31:0]              deep_sleep_gating_word_zero
);
   import dcap_pkg::*;

   dcap_state_t st;
   dcap_state_t next_st;

   // register select from address
   function automatic dcap_sel_t dcap_decode(input logic [11:0] a);
      case (a)
         `DCAP_OFS_CORE:     dcap_decode = DCAP_SEL_CORE;
         `DCAP_OFS_UNIT:     dcap_decode = DCAP_SEL_UNIT;
         `DCAP_OFS_PIN:      dcap_decode = DCAP_SEL_PIN;
         `DCAP_OFS_RUN_GATE: dcap_decode = DCAP_SEL_RUN;
         `DCAP_OFS_SLP_GATE: dcap_decode = DCAP_SEL_SLP;
         `DCAP_OFS_DSL_GATE: dcap_decode = DCAP_SEL_DSL;
         default:            dcap_decode = DCAP_SEL_NONE;
      endcase
   endfunction : dcap_decode

   // core feature word, built field by field
   function automatic logic [31:0] dcap_core_word();
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`DCAP_BIT_PWM] = 1'b1;                                   // R1
      w[`DCAP_BIT_ADC] = 1'b1;                                   // R2
      w[`DCAP_DIV_HI:`DCAP_DIV_LO] = `DCAP_MIN_DIV_VAL;          // R3
      w[`DCAP_RATE_HI:`DCAP_RATE_LO] = `DCAP_MAX_RATE_VAL;       // R4
      w[`DCAP_BIT_MPU] = 1'b1;                                   // R5
      w[`DCAP_BIT_TEMP] = 1'b1;                                  // R6
      w[`DCAP_BIT_PLL] = 1'b1;                                   // R7
      w[`DCAP_BIT_WDT] = 1'b1;                                   // R8
      w[`DCAP_BIT_TRACE] = 1'b1;                                 // R9
      w[`DCAP_BIT_SWDBG] = 1'b1;                                 // R9
      w[`DCAP_BIT_SCAN] = 1'b1;                                  // R9
      return w;
   endfunction : dcap_core_word

   // gating write: absent units and unmarked bits forced low, speed clipped
   function automatic logic [31:0] dcap_mask_gate(input logic [31:0] wd);
      logic [31:0] cw;
      logic [31:0] m;
      logic [3:0]  spd;
      cw  = dcap_core_word();
      m   = wd & `DCAP_GATE_MARK & cw;                           // R10 R11
      spd = wd[`DCAP_RATE_HI:`DCAP_RATE_LO];
      if (spd > cw[`DCAP_RATE_HI:`DCAP_RATE_LO]) begin
         spd = cw[`DCAP_RATE_HI:`DCAP_RATE_LO];                  // R12
      end
      m[`DCAP_RATE_HI:`DCAP_RATE_LO] = spd;
      return m;
   endfunction : dcap_mask_gate

   always_comb begin
      dcap_sel_t sel;
      sel           = dcap_decode(req.addr);
      next_st       = st;
      next_st.rdata = 32'h0000_0000;
      next_st.rvalid = req.rd;
      // capability words ignore writes entirely
      if (req.wr) begin                                          // R21
         for (int i = 0; i < 3; i++) begin
            if (sel == dcap_sel_t'(DCAP_SEL_RUN + i)) begin
               next_st.gate[i] = dcap_mask_gate(req.wdata);      // R10
            end
         end
      end
      if (req.rd) begin
         unique case (sel)
            DCAP_SEL_CORE: next_st.rdata = dcap_core_word();
            DCAP_SEL_UNIT: next_st.rdata = `DCAP_UNIT_VAL;       // R13 R14 R15
            DCAP_SEL_PIN:  next_st.rdata = `DCAP_PIN_VAL;        // R16 R17 R18 R19
            DCAP_SEL_RUN:  next_st.rdata = st.gate[0];
            DCAP_SEL_SLP:  next_st.rdata = st.gate[1];
            DCAP_SEL_DSL:  next_st.rdata = st.gate[2];
            DCAP_SEL_NONE: next_st.rdata = 32'h0000_0000;        // R20
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st.rdata  <= 32'h0000_0000;
         st.rvalid <= 1'b0;
         st.gate   <= {3{`DCAP_GATE_RST}};
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata                   = st.rdata;
   assign reg_rvalid                  = st.rvalid;
   assign run_gating_word_zero        = st.gate[0];
   assign sleep_gating_word_zero      = st.gate[1];
   assign deep_sleep_gating_word_zero = st.gate[2];

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   a_core_pwm_bit: assert property ( // R1
      (req.rd && req.addr == `DCAP_OFS_CORE) |=> reg_rvalid && reg_rdata[20] == 1'b1)
      else $error("modulator presence bit not set");

   a_core_adc_bit: assert property ( // R2
      (req.rd && req.addr == `DCAP_OFS_CORE) |=> reg_rdata[16] == 1'b1)
      else $error("converter presence bit not set");

   a_core_min_div: assert property ( // R3
      (req.rd && req.addr == `DCAP_OFS_CORE) |=> reg_rdata[15:12] == 4'h9)
      else $error("minimum divider field wrong");

   a_core_max_rate: assert property ( // R4
      (req.rd && req.addr == `DCAP_OFS_CORE) |=> reg_rdata[11:8] == 4'h1)
      else $error("maximum converter rate field wrong");

   a_core_mpu_bit: assert property ( // R5
      (req.rd && req.addr == `DCAP_OFS_CORE) |=> reg_rdata[7] == 1'b1)
      else $error("protection unit bit not set");

   a_core_temp_bit: assert property ( // R6
      (req.rd && req.addr == `DCAP_OFS_CORE) |=> reg_rdata[5] == 1'b1)
      else $error("temperature sensor bit not set");

   a_core_pll_bit: assert property ( // R7
      (req.rd && req.addr == `DCAP_OFS_CORE) |=> reg_rdata[4] == 1'b1)
      else $error("loop presence bit not set");

   a_core_wdt_bit: assert property ( // R8
      (req.rd && req.addr == `DCAP_OFS_CORE) |=> reg_rdata[3] == 1'b1)
      else $error("watchdog bit not set");

   a_core_debug_ports: assert property ( // R9
      (req.rd && req.addr == `DCAP_OFS_CORE) |=> reg_rdata[2:0] == 3'h7)
      else $error("debug port bits not set");

   a_gate_follows_mask: assert property ( // R10
      (req.wr && req.addr == `DCAP_OFS_RUN_GATE)
      |=> run_gating_word_zero[20] == $past(req.wdata[20])
          && run_gating_word_zero[3:0] == $past(req.wdata[3:0]))
      else $error("run gating word ignored a marked bit");

   a_gate_unmarked_zero: assert property ( // R11
      ((run_gating_word_zero | sleep_gating_word_zero | deep_sleep_gating_word_zero)
       & ~32'h0011_0f0f) == 32'h0000_0000)
      else $error("unmarked gating bit is set");

   a_gate_speed_clip: assert property ( // R12
      (req.wr && req.addr == `DCAP_OFS_SLP_GATE && req.wdata[11:8] > 4'h1)
      |=> sleep_gating_word_zero[11:8] == 4'h1)
      else $error("converter speed not clipped");

   a_unit_comparators: assert property ( // R13
      (req.rd && req.addr == `DCAP_OFS_UNIT) |=> reg_rdata[25:24] == 2'h3)
      else $error("comparator presence bits wrong");

   a_unit_timers: assert property ( // R14
      (req.rd && req.addr == `DCAP_OFS_UNIT) |=> reg_rdata[17:16] == 2'h3)
      else $error("timer presence bits wrong");

   a_unit_serial_uart: assert property ( // R15
      (req.rd && req.addr == `DCAP_OFS_UNIT) |=> reg_rdata[4] && reg_rdata[0])
      else $error("serial or uart bit wrong");

   a_pin_capture: assert property ( // R16
      (req.rd && req.addr == `DCAP_OFS_PIN) |=> reg_rdata[26:24] == 3'h5)
      else $error("capture pin bits wrong");

   a_pin_converter: assert property ( // R17
      (req.rd && req.addr == `DCAP_OFS_PIN) |=> reg_rdata[18:16] == 3'h7)
      else $error("converter input pin bits wrong");

   a_pin_comparator: assert property ( // R18
      (req.rd && req.addr == `DCAP_OFS_PIN) |=> reg_rdata[11:6] == 6'h3f)
      else $error("comparator pin bits wrong");

   a_pin_modulator: assert property ( // R19
      (req.rd && req.addr == `DCAP_OFS_PIN) |=> reg_rdata[1:0] == 2'h3)
      else $error("modulator pin bits wrong");

   a_data_one_cycle: assert property ( // R20
      !req.rd |=> !reg_rvalid && reg_rdata == 32'h0000_0000)
      else $error("read data outside its cycle");

   a_cap_write_inert: assert property ( // R21
      (req.wr && req.addr == `DCAP_OFS_UNIT) ##1 (req.rd && req.addr == `DCAP_OFS_UNIT)
      |=> reg_rdata == 32'h0303_0011)
      else $error("capability word changed by write");

   // gating words checked one by one: run, sleep, deep sleep
   a_run_mask_conv: assert property ( // R10
      (req.wr && req.addr == `DCAP_OFS_RUN_GATE)
      |=> run_gating_word_zero[16] == $past(req.wdata[16]))
      else $error("run gating word lost the converter bit");

   a_slp_mask_bits: assert property ( // R10
      (req.wr && req.addr == `DCAP_OFS_SLP_GATE)
      |=> sleep_gating_word_zero[20] == $past(req.wdata[20])
          && sleep_gating_word_zero[16] == $past(req.wdata[16])
          && sleep_gating_word_zero[3:0] == $past(req.wdata[3:0]))
      else $error("sleep gating word ignored a marked bit");

   a_dsl_mask_bits: assert property ( // R10
      (req.wr && req.addr == `DCAP_OFS_DSL_GATE)
      |=> deep_sleep_gating_word_zero[20] == $past(req.wdata[20])
          && deep_sleep_gating_word_zero[16] == $past(req.wdata[16])
          && deep_sleep_gating_word_zero[3:0] == $past(req.wdata[3:0]))
      else $error("deep sleep gating word ignored a marked bit");

   a_run_speed_clip: assert property ( // R12
      (req.wr && req.addr == `DCAP_OFS_RUN_GATE && req.wdata[11:8] > 4'h1)
      |=> run_gating_word_zero[11:8] == 4'h1)
      else $error("run converter speed not clipped");

   a_dsl_speed_clip: assert property ( // R12
      (req.wr && req.addr == `DCAP_OFS_DSL_GATE && req.wdata[11:8] > 4'h1)
      |=> deep_sleep_gating_word_zero[11:8] == 4'h1)
      else $error("deep sleep converter speed not clipped");

   a_run_speed_pass: assert property ( // R12
      (req.wr && req.addr == `DCAP_OFS_RUN_GATE && req.wdata[11:8] <= 4'h1)
      |=> run_gating_word_zero[11:8] == $past(req.wdata[11:8]))
      else $error("run converter speed altered below the limit");

   a_slp_speed_pass: assert property ( // R12
      (req.wr && req.addr == `DCAP_OFS_SLP_GATE && req.wdata[11:8] <= 4'h1)
      |=> sleep_gating_word_zero[11:8] == $past(req.wdata[11:8]))
      else $error("sleep converter speed altered below the limit");

   a_dsl_speed_pass: assert property ( // R12
      (req.wr && req.addr == `DCAP_OFS_DSL_GATE && req.wdata[11:8] <= 4'h1)
      |=> deep_sleep_gating_word_zero[11:8] == $past(req.wdata[11:8]))
      else $error("deep sleep converter speed altered below the limit");

   a_run_word_hold: assert property ( // R10
      !(req.wr && req.addr == `DCAP_OFS_RUN_GATE)
      |=> $stable(run_gating_word_zero))
      else $error("run gating word changed without a write");

   a_slp_word_hold: assert property ( // R10
      !(req.wr && req.addr == `DCAP_OFS_SLP_GATE)
      |=> $stable(sleep_gating_word_zero))
      else $error("sleep gating word changed without a write");

   a_dsl_word_hold: assert property ( // R10
      !(req.wr && req.addr == `DCAP_OFS_DSL_GATE)
      |=> $stable(deep_sleep_gating_word_zero))
      else $error("deep sleep gating word changed without a write");

   a_run_readback: assert property ( // R10
      (req.rd && req.addr == `DCAP_OFS_RUN_GATE)
      |=> reg_rvalid && reg_rdata == $past(run_gating_word_zero))
      else $error("run gating word read back wrong");

   a_slp_readback: assert property ( // R10
      (req.rd && req.addr == `DCAP_OFS_SLP_GATE)
      |=> reg_rvalid && reg_rdata == $past(sleep_gating_word_zero))
      else $error("sleep gating word read back wrong");

   a_dsl_readback: assert property ( // R10
      (req.rd && req.addr == `DCAP_OFS_DSL_GATE)
      |=> reg_rvalid && reg_rdata == $past(deep_sleep_gating_word_zero))
      else $error("deep sleep gating word read back wrong");

   a_run_unmarked_zero: assert property ( // R11
      (run_gating_word_zero & ~`DCAP_GATE_MARK) == 32'h0000_0000)
      else $error("unmarked run gating bit is set");

   a_slp_unmarked_zero: assert property ( // R11
      (sleep_gating_word_zero & ~`DCAP_GATE_MARK) == 32'h0000_0000)
      else $error("unmarked sleep gating bit is set");

   a_dsl_unmarked_zero: assert property ( // R11
      (deep_sleep_gating_word_zero & ~`DCAP_GATE_MARK) == 32'h0000_0000)
      else $error("unmarked deep sleep gating bit is set");

   a_run_write_alone: assert property ( // R10
      (req.wr && req.addr == `DCAP_OFS_RUN_GATE)
      |=> $stable(sleep_gating_word_zero) && $stable(deep_sleep_gating_word_zero))
      else $error("run gating write reached another word");

   a_slp_write_alone: assert property ( // R10
      (req.wr && req.addr == `DCAP_OFS_SLP_GATE)
      |=> $stable(run_gating_word_zero) && $stable(deep_sleep_gating_word_zero))
      else $error("sleep gating write reached another word");

   a_dsl_write_alone: assert property ( // R10
      (req.wr && req.addr == `DCAP_OFS_DSL_GATE)
      |=> $stable(run_gating_word_zero) && $stable(sleep_gating_word_zero))
      else $error("deep sleep gating write reached another word");

   a_run_reset_zero: assert property ( // R10
      $fell(rst) |-> run_gating_word_zero == 32'h0000_0000)
      else $error("run gating word not cleared by reset");

   a_slp_reset_zero: assert property ( // R10
      $fell(rst) |-> sleep_gating_word_zero == 32'h0000_0000)
      else $error("sleep gating word not cleared by reset");

   a_dsl_reset_zero: assert property ( // R10
      $fell(rst) |-> deep_sleep_gating_word_zero == 32'h0000_0000)
      else $error("deep sleep gating word not cleared by reset");

   a_run_speed_ceiling: assert property ( // R12
      run_gating_word_zero[11:8] <= 4'h1)
      else $error("run converter speed above the maximum rate");

   a_slp_speed_ceiling: assert property ( // R12
      sleep_gating_word_zero[11:8] <= 4'h1)
      else $error("sleep converter speed above the maximum rate");

   a_dsl_speed_ceiling: assert property ( // R12
      deep_sleep_gating_word_zero[11:8] <= 4'h1)
      else $error("deep sleep converter speed above the maximum rate");

   a_run_marks_off: assert property ( // R11
      (req.wr && req.addr == `DCAP_OFS_RUN_GATE && (req.wdata & `DCAP_GATE_MARK) == 32'h0000_0000)
      |=> run_gating_word_zero == 32'h0000_0000)
      else $error("run gating word kept an unmarked bit");

   a_slp_marks_off: assert property ( // R11
      (req.wr && req.addr == `DCAP_OFS_SLP_GATE && (req.wdata & `DCAP_GATE_MARK) == 32'h0000_0000)
      |=> sleep_gating_word_zero == 32'h0000_0000)
      else $error("sleep gating word kept an unmarked bit");

   a_dsl_marks_off: assert property ( // R11
      (req.wr && req.addr == `DCAP_OFS_DSL_GATE && (req.wdata & `DCAP_GATE_MARK) == 32'h0000_0000)
      |=> deep_sleep_gating_word_zero == 32'h0000_0000)
      else $error("deep sleep gating word kept an unmarked bit");

   a_read_valid_pulse: assert property ( // R20
      req.rd |=> reg_rvalid)
      else $error("read not answered in the next cycle");

   a_unmapped_read_zero: assert property ( // R20
      (req.rd && dcap_decode(req.addr) == DCAP_SEL_NONE)
      |=> reg_rvalid && reg_rdata == 32'h0000_0000)
      else $error("unmapped read returned data");

   a_core_reserved_zero: assert property ( // R20
      (req.rd && req.addr == `DCAP_OFS_CORE)
      |=> (reg_rdata & ~32'h0011_91bf) == 32'h0000_0000)
      else $error("reserved core word bit is set");

   a_unit_reserved_zero: assert property ( // R20
      (req.rd && req.addr == `DCAP_OFS_UNIT)
      |=> (reg_rdata & ~32'h0303_0011) == 32'h0000_0000)
      else $error("reserved unit word bit is set");

   a_pin_reserved_zero: assert property ( // R20
      (req.rd && req.addr == `DCAP_OFS_PIN)
      |=> (reg_rdata & ~32'h0507_0fc3) == 32'h0000_0000)
      else $error("reserved pin word bit is set");

   a_pin_bit25_clear: assert property ( // R16
      (req.rd && req.addr == `DCAP_OFS_PIN)
      |=> reg_rdata[25] == 1'b0)
      else $error("reserved capture pin bit is set");

   a_core_write_inert: assert property ( // R21
      (req.wr && req.addr == `DCAP_OFS_CORE) ##1 (req.rd && req.addr == `DCAP_OFS_CORE)
      |=> reg_rdata == 32'h0011_91bf)
      else $error("core word changed by write");

   a_pin_write_inert: assert property ( // R21
      (req.wr && req.addr == `DCAP_OFS_PIN) ##1 (req.rd && req.addr == `DCAP_OFS_PIN)
      |=> reg_rdata == 32'h0507_0fc3)
      else $error("pin word changed by write");

   a_cap_write_no_gate: assert property ( // R21
      (req.wr && (dcap_decode(req.addr) == DCAP_SEL_CORE || dcap_decode(req.addr) == DCAP_SEL_UNIT
                  || dcap_decode(req.addr) == DCAP_SEL_PIN))
      |=> $stable(run_gating_word_zero) && $stable(sleep_gating_word_zero)
          && $stable(deep_sleep_gating_word_zero))
      else $error("capability write changed a gating word");

   a_stray_write_inert: assert property ( // R10
      (req.wr && dcap_decode(req.addr) == DCAP_SEL_NONE)
      |=> $stable(run_gating_word_zero) && $stable(sleep_gating_word_zero)
          && $stable(deep_sleep_gating_word_zero))
      else $error("unmapped write changed a gating word");

endmodule : dcap_regs

// File: dcap_params.svh
// constants for the device capability register bank
// Function
// [R1] core word bit 20 reports modulator present
// [R2] core word bit 16 reports converter present
// [R3] bits 15:12 hold minimum divider 0x9
// [R4] bits 11:8 hold maximum converter rate 0x1
// [R5] core word bit 7 reports protection unit
// [R6] core word bit 5 reports temperature sensor
// [R7] core word bit 4 reports loop present
// [R8] core word bit 3 reports watchdog present
// [R9] bits 2..0 report trace, two-wire, scan ports
// [R10] marked core bits mask all gating words
// [R11] unmarked gating bits always read zero
// [R12] converter speed clipped to maximum rate
// [R13] unit word bits 25,24 report comparators
// [R14] unit word bits 17,16 report timers
// [R15] unit word bits 4,0 serial, first uart
// [R16] pin word bits 26,24 capture pins; 25 reserved
// [R17] pin word bits 18..16 converter inputs
// [R18] pin word bits 11..6 comparator pins
// [R19] pin word bits 1,0 modulator pins
// [R20] reserved bits read-only, software ignores them
// [R21] writes to capability words change nothing
`ifndef DCAP_PARAMS_SVH
`define DCAP_PARAMS_SVH

`define DCAP_ADDR_W        12
`define DCAP_OFS_CORE      12'h010
`define DCAP_OFS_UNIT      12'h014
`define DCAP_OFS_PIN       12'h018
`define DCAP_OFS_RUN_GATE  12'h100
`define DCAP_OFS_SLP_GATE  12'h104
`define DCAP_OFS_DSL_GATE  12'h108

`define DCAP_BIT_PWM       20
`define DCAP_BIT_ADC       16
`define DCAP_DIV_HI        15
`define DCAP_DIV_LO        12
`define DCAP_RATE_HI       11
`define DCAP_RATE_LO       8
`define DCAP_BIT_MPU       7
`define DCAP_BIT_TEMP      5
`define DCAP_BIT_PLL       4
`define DCAP_BIT_WDT       3
`define DCAP_BIT_TRACE     2
`define DCAP_BIT_SWDBG     1
`define DCAP_BIT_SCAN      0

`define DCAP_MIN_DIV_VAL   4'h9
`define DCAP_MAX_RATE_VAL  4'h1
`define DCAP_UNIT_VAL      32'h0303_0011
`define DCAP_PIN_VAL       32'h0507_0fc3
`define DCAP_GATE_MARK     32'h0011_0f0f
`define DCAP_GATE_RST      32'h0000_0000

`endif

// File: dcap_pkg.sv
// types for the device capability register bank
package dcap_pkg;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } dcap_req_t;

   typedef enum logic [2:0] {
      DCAP_SEL_NONE = 3'h0,
      DCAP_SEL_CORE = 3'h1,
      DCAP_SEL_UNIT = 3'h2,
      DCAP_SEL_PIN  = 3'h3,
      DCAP_SEL_RUN  = 3'h4,
      DCAP_SEL_SLP  = 3'h5,
      DCAP_SEL_DSL  = 3'h6
   } dcap_sel_t;

   typedef struct packed {
      logic [31:0]       rdata;
      logic              rvalid;
      logic [2:0][31:0]  gate;
   } dcap_state_t;

endpackage : dcap_pkg

// File: dcap_regs_tb_top.sv
// self-checking bench for the capability words and the masked gating words
`timescale 1ns/10ps
`include "dcap_params.svh"

module dcap_regs_tb_top;
   import dcap_pkg::*;

   logic        core_clk = 1'b0;
   logic        rst;
   dcap_req_t   req;
   logic [31:0] reg_rdata;
   logic        reg_rvalid;
   logic [31:0] run_gating_word_zero;
   logic [31:0] sleep_gating_word_zero;
   logic [31:0] deep_sleep_gating_word_zero;
   logic [31:0] pend_data;
   logic        pend_valid;
   int          err_count = 0;
   int          cmp_count = 0;
   int          cycles    = 0;
   logic [31:0] cap_val [3] = '{32'h001191bf, 32'h03030011, 32'h05070fc3};
   logic [11:0] gate_ofs [3] = '{`DCAP_OFS_RUN_GATE, `DCAP_OFS_SLP_GATE, `DCAP_OFS_DSL_GATE};
   logic [31:0] wr_val [4] = '{32'hffffffff, 32'hffeef0f0, 32'h00000300, 32'h00100009};
   logic [31:0] exp_val [4] = '{32'h0011010f, 32'h00000000, 32'h00000100, 32'h00100009};

   dcap_regs dcap_regs_i (
      .core_clk                    (core_clk),
      .rst                         (rst),
      .req                         (req),
      .reg_rdata                   (reg_rdata),
      .reg_rvalid                  (reg_rvalid),
      .run_gating_word_zero        (run_gating_word_zero),
      .sleep_gating_word_zero      (sleep_gating_word_zero),
      .deep_sleep_gating_word_zero (deep_sleep_gating_word_zero)
   );

   always #25 core_clk = ~core_clk;

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : tally_and_finish

   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 2000) begin
         err_count = err_count + 1;
         tally_and_finish();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", name, exp, got);
         err_count = err_count + 1;
      end
   endtask : chk

   function automatic logic [31:0] gate_of(input int g);
      case (g)
         0: return run_gating_word_zero;
         1: return sleep_gating_word_zero;
         default: return deep_sleep_gating_word_zero;
      endcase
   endfunction : gate_of

   // one bus cycle; also checks the answer to the previous cycle
   task automatic step(input logic w, input logic r, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp_rd);
      @(posedge core_clk);
      req <= '{addr: a, wdata: d, wr: w, rd: r};
      #1;
      chk("reg_rvalid", {31'h0, pend_valid}, {31'h0, reg_rvalid});
      chk("reg_rdata", pend_data, reg_rdata);
      pend_valid = r;
      pend_data  = r ? exp_rd : 32'h0;
   endtask : step

   initial begin
      rst        = 1'b1;
      req        = '0;
      pend_data  = '0;
      pend_valid = 1'b0;
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      for (int g = 0; g < 3; g++) chk("gate after reset", 32'h0, gate_of(g));
      // back-to-back reads, an unmapped read last
      step(0, 1, `DCAP_OFS_CORE, 32'h0, cap_val[0]);
      step(0, 1, `DCAP_OFS_UNIT, 32'h0, cap_val[1]);
      step(0, 1, `DCAP_OFS_PIN, 32'h0, cap_val[2]);
      step(0, 1, 12'h01c, 32'h0, 32'h0);
      for (int i = 0; i < 3; i++) begin
         step(1, 0, 12'h010 + 12'(4 * i), 32'hffffffff, 32'h0);
         step(0, 1, 12'h010 + 12'(4 * i), 32'h0, cap_val[i]);
      end
      // each gating word: write then read straight after
      for (int g = 0; g < 3; g++) begin
         for (int k = 0; k < 4; k++) begin
            step(1, 0, gate_ofs[g], wr_val[k], 32'h0);
            step(0, 1, gate_ofs[g], 32'h0, exp_val[k]);
            chk("gating output", exp_val[k], gate_of(g));
         end
      end
      step(1, 0, 12'h10c, 32'hffffffff, 32'h0);
      step(0, 0, 12'h0, 32'h0, 32'h0);
      step(0, 0, 12'h0, 32'h0, 32'h0);
      for (int g = 0; g < 3; g++) chk("gate kept", exp_val[3], gate_of(g));
      // second reset in mid-run clears the gating words at once
      @(posedge core_clk);
      rst <= 1'b1;
      #1;
      for (int g = 0; g < 3; g++) chk("gate in reset", 32'h0, gate_of(g));
      pend_valid = 1'b0;
      pend_data  = 32'h0;
      @(posedge core_clk);
      rst <= 1'b0;
      step(0, 1, `DCAP_OFS_CORE, 32'h0, cap_val[0]);
      step(0, 0, 12'h0, 32'h0, 32'h0);
      step(0, 0, 12'h0, 32'h0, 32'h0);
      tally_and_finish();
   end

endmodule : dcap_regs_tb_top
